// [verification/scfc_top_bench.sv]
// Purpose: Self-checking bench for scfc_top
// Assumes: Main pin period 10 mclk, sub pin period 34 mclk
// Notes:   Periods are measured between phi rising edges
`timescale 1ns/1ns
module scfc_top_bench;
  logic       mclk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       main_osc_in = 1'b0;
  logic       sub_osc_in = 1'b0;
  logic       wait_instruction_in = 1'b0;
  logic       int_accept_in = 1'b0;
  logic       main_osc_run_out;
  logic       sub_osc_run_out;
  logic       sub_pins_port_out;
  logic       sys_clk_out;
  logic       waiting_out;
  int         main_cnt = 0;
  int         sub_cnt = 0;
  int         n_errors = 0;
  int         checked = 0;

  scfc_top i_scfc_top (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in),
    .wait_instruction_in(wait_instruction_in), .int_accept_in(int_accept_in),
    .main_osc_run_out(main_osc_run_out), .sub_osc_run_out(sub_osc_run_out),
    .sub_pins_port_out(sub_pins_port_out), .sys_clk_out(sys_clk_out),
    .waiting_out(waiting_out)
  );

  always #5 mclk_in = ~mclk_in;

  // A stopped oscillator stops toggling its pin
  always @(posedge mclk_in) begin
    if (main_osc_run_out === 1'b1) begin
      main_cnt <= (main_cnt == 4) ? 0 : main_cnt + 1;
      if (main_cnt == 4) main_osc_in <= ~main_osc_in;
    end
    if (sub_osc_run_out === 1'b1) begin
      sub_cnt <= (sub_cnt == 16) ? 0 : sub_cnt + 1;
      if (sub_cnt == 16) sub_osc_in <= ~sub_osc_in;
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out & m, exp);
  endtask

  task automatic phi_rise(output int n);
    logic last;
    n = 0;
    #1;
    last = sys_clk_out;
    while (n < 1000) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (sys_clk_out === 1'b1 && last !== 1'b1) break;
      last = sys_clk_out;
    end
    if (n >= 1000) begin
      n_errors++;
      $display("CHECK FAILED t=%0t no phi edge", $time);
      complete_run();
    end
  endtask

  // Third rise: new mode is applied only at a period boundary
  task automatic period(input int exp);
    int n;
    phi_rise(n);
    phi_rise(n);
    phi_rise(n);
    chkn(n, exp);
  endtask

  task automatic do_reset();
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    #1;
    chk({4'h0, main_osc_run_out, sub_osc_run_out, sub_pins_port_out, sys_clk_out}, 8'h0b);
    chk({7'h0, waiting_out}, 8'h00);
    @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(8'h3b, 8'h48, 8'hff);
    period(80);
  endtask

  task automatic t_modes();
    wr(8'h3b, 8'h18);
    @(posedge mclk_in);
    #1;
    chk({6'h0, sub_osc_run_out, sub_pins_port_out}, 8'h02);
    period(20);
    rd(8'h3b, 8'h18, 8'hff);
    wr(8'h3b, 8'h98);
    period(68);
    rd(8'h40, 8'h34, 8'hfe);
  endtask

  task automatic t_stop();
    wr(8'h3b, 8'hb8);
    repeat (3) @(posedge mclk_in);
    #1;
    chk({7'h0, main_osc_run_out}, 8'h00);
    period(68);
    wr(8'h3b, 8'h98);
    repeat (3) @(posedge mclk_in);
    #1;
    chk({7'h0, main_osc_run_out}, 8'h01);
    repeat (40) @(posedge mclk_in);
    wr(8'h3b, 8'h58);
    period(80);
    wr(8'h3b, 8'h78);
    repeat (3) @(posedge mclk_in);
    #1;
    chk({7'h0, main_osc_run_out}, 8'h01);
  endtask

  task automatic t_wait();
    int lows;
    lows = 0;
    @(posedge mclk_in);
    wait_instruction_in <= 1'b1;
    @(posedge mclk_in);
    wait_instruction_in <= 1'b0;
    #1;
    chk({7'h0, waiting_out}, 8'h01);
    // Phi may first finish a low phase of up to 40 cycles
    repeat (50) @(posedge mclk_in);
    repeat (200) begin
      @(posedge mclk_in);
      #1;
      if (sys_clk_out !== 1'b1) lows++;
    end
    chkn(lows, 0);
    @(posedge mclk_in);
    int_accept_in <= 1'b1;
    @(posedge mclk_in);
    int_accept_in <= 1'b0;
    #1;
    chk({7'h0, waiting_out}, 8'h00);
    period(80);
  endtask

  task automatic t_refused();
    rd(8'h41, 8'h00, 8'hff);
    wr(8'h40, 8'hff);
    wr(8'h3c, 8'h00);
    rd(8'h3b, 8'h78, 8'hff);
    // Illegal speed code must run as middle speed
    wr(8'h3b, 8'hd8);
    period(80);
    rd(8'h40, 8'h32, 8'hfe);
    // Leave a wait pending so the next reset must release it
    @(posedge mclk_in);
    wait_instruction_in <= 1'b1;
    @(posedge mclk_in);
    wait_instruction_in <= 1'b0;
    #1;
    chk({7'h0, waiting_out}, 8'h01);
  endtask

  initial begin
    do_reset();
    t_modes();
    t_stop();
    t_wait();
    t_refused();
    do_reset();
    complete_run();
  end
endmodule

// [verilog/scfc_cfg.svh]
// Purpose: Constants of the system clock frequency control block
// Assumes: Byte-wide register port, 100 MHz sampling clock
// Notes:   Offsets, field positions, reset values and divide counts
`ifndef SCFC_CFG_SVH
`define SCFC_CFG_SVH

`define SCFC_ADDR_W         8
`define SCFC_DATA_W         8
`define SCFC_PMR_ADDR       8'h3b
`define SCFC_STAT_ADDR      8'h40
`define SCFC_PMR_RESET      8'h48
`define SCFC_SPEED_MSB      7
`define SCFC_SPEED_LSB      6
`define SCFC_MAIN_STOP_BIT  5
`define SCFC_SUB_EN_BIT     4
`define SCFC_STAT_PHI_BIT   0
`define SCFC_STAT_MODE_LSB  1
`define SCFC_STAT_MODE_MSB  2
`define SCFC_STAT_WAIT_BIT  3
`define SCFC_STAT_MAIN_BIT  4
`define SCFC_STAT_SUB_BIT   5
`define SCFC_CNT_W          3
`define SCFC_HALF_MID       4
`define SCFC_HALF_HIGH      1
`define SCFC_HALF_LOW       1

`endif

// [verilog/scfc_pin_sync.sv]
// Purpose: Three-stage pin synchroniser with rising-edge pulse
// Assumes: Pin toggles well below half the sampling rate
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ns
module scfc_pin_sync (
  input  wire logic mclk_in,    // Sampling clock
  input  wire logic arst_n_in,  // Async reset, active low
  input  wire logic pin_in,     // Asynchronous pin
  output logic      level_out,  // Filtered level
  output logic      rise_out    // One-cycle pulse on rising edge
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_out <= 1'b0;
      rise_out  <= 1'b0;
    end else begin
      rise_out <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_out) begin
        level_out <= s3_reg;
        rise_out  <= s3_reg;
      end
    end
  end

endmodule

// [verilog/scfc_pkg.sv]
// Purpose: Types of the system clock frequency control block
// Assumes: Constants come from scfc_cfg.svh
// Notes:   Code 2'b11 of the speed field is not a legal mode
package scfc_pkg;

  typedef enum logic [1:0] {
    SCFC_SPEED_HIGH = 2'b00,
    SCFC_SPEED_MID  = 2'b01,
    SCFC_SPEED_LOW  = 2'b10
  } scfc_speed_e;

endpackage

// [verilog/scfc_top.sv]
// Purpose: System clock generation and frequency control
// Assumes: Oscillator pins are sampled at 100 MHz; software respects timing notes
// Notes:   Half periods count synchronised source rising edges
// Operation
// - After reset the block runs middle speed, system clock is main divided by eight.
// - High-speed mode makes the system clock half the main oscillator frequency.
// - Low-speed mode makes the system clock half the sub oscillator frequency.
// - At power-on only the main oscillator runs and the sub pins act as port pins.
// - In low-speed mode, main stop bit 5 set halts the main oscillator, clear restarts it.
// - The wait instruction holds the system clock high until reset or an accepted interrupt.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`include "scfc_cfg.svh"
module scfc_top
  import scfc_pkg::*;
#(
  parameter int HALF_MID  = `SCFC_HALF_MID,
  parameter int HALF_HIGH = `SCFC_HALF_HIGH,
  parameter int HALF_LOW  = `SCFC_HALF_LOW
) (
  input  wire logic                    mclk_in,          // 100 MHz clock
  input  wire logic                    arst_n_in,        // Async reset, active low
  input  wire logic [`SCFC_ADDR_W-1:0] reg_addr_in,      // Register address
  input  wire logic [`SCFC_DATA_W-1:0] reg_wdata_in,     // Write data
  input  wire logic                    reg_wr_in,        // Write strobe
  input  wire logic                    reg_rd_in,        // Read strobe
  output logic      [`SCFC_DATA_W-1:0] reg_rdata_out,    // Read data, one cycle later
  input  wire logic                    main_osc_in,      // Main oscillator pin
  input  wire logic                    sub_osc_in,       // Sub oscillator pin
  input  wire logic                    wait_instruction_in, // Wait executed, pulse
  input  wire logic                    int_accept_in,    // Interrupt accepted, pulse
  output logic                         main_osc_run_out, // Main oscillator enable
  output logic                         sub_osc_run_out,  // Sub oscillator enable
  output logic                         sub_pins_port_out,// Sub pins act as port pins
  output logic                         sys_clk_out,      // Internal system clock
  output logic                         waiting_out       // Clock held by wait
);

  logic [`SCFC_DATA_W-1:0] pmr_reg;
  logic [`SCFC_DATA_W-1:0] rdata_next;
  logic [`SCFC_CNT_W-1:0]  cnt_reg;
  logic [`SCFC_CNT_W-1:0]  half_m1;
  scfc_speed_e             applied_reg;
  scfc_speed_e             wanted;
  logic                    phi_reg;
  logic                    wait_reg;
  logic                    main_run_reg;
  logic                    sub_run_reg;
  logic                    main_rise;
  logic                    sub_rise;
  logic                    src_tick;
  logic                    freeze;
  logic                    last_half;
  logic                    pmr_wr;
  logic                    main_stop_req;

  // Oscillator pins are asynchronous to mclk
  scfc_pin_sync u_main_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .pin_in    (main_osc_in),
    .level_out (),
    .rise_out  (main_rise)
  );

  scfc_pin_sync u_sub_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .pin_in    (sub_osc_in),
    .level_out (),
    .rise_out  (sub_rise)
  );

  assign pmr_wr = reg_wr_in && (reg_addr_in == `SCFC_PMR_ADDR);

  // Mode register; reset code selects middle speed
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pmr_reg <= `SCFC_PMR_RESET;
    end else if (pmr_wr) begin
      pmr_reg <= reg_wdata_in;
    end
  end

  // Illegal speed code falls back to middle speed, the safest ratio
  always_comb begin
    unique case (pmr_reg[`SCFC_SPEED_MSB:`SCFC_SPEED_LSB])
      2'b00:   wanted = SCFC_SPEED_HIGH;
      2'b10:   wanted = SCFC_SPEED_LOW;
      default: wanted = SCFC_SPEED_MID;
    endcase
  end

  // Stop bit only acts while low speed is the running mode
  assign main_stop_req = pmr_reg[`SCFC_MAIN_STOP_BIT] && (applied_reg == SCFC_SPEED_LOW);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      main_run_reg <= 1'b1;
      sub_run_reg  <= 1'b0;
    end else begin
      main_run_reg <= !main_stop_req;
      sub_run_reg  <= pmr_reg[`SCFC_SUB_EN_BIT];
    end
  end

  // Stopped oscillators give no ticks even if the pin still wiggles
  assign src_tick = (applied_reg == SCFC_SPEED_LOW) ? (sub_rise && sub_run_reg) :
                    (main_rise && main_run_reg);

  always_comb begin
    unique case (applied_reg)
      SCFC_SPEED_HIGH: half_m1 = `SCFC_CNT_W'(HALF_HIGH - 1);
      SCFC_SPEED_LOW:  half_m1 = `SCFC_CNT_W'(HALF_LOW - 1);
      default:         half_m1 = `SCFC_CNT_W'(HALF_MID - 1);
    endcase
  end

  assign freeze    = wait_reg && phi_reg;
  assign last_half = src_tick && !freeze && (cnt_reg == half_m1);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= '0;
    end else if (src_tick && !freeze) begin
      cnt_reg <= last_half ? '0 : cnt_reg + `SCFC_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phi_reg <= 1'b1;
    end else if (last_half) begin
      phi_reg <= !phi_reg;
    end
  end

  // New ratio starts with a fresh period, so no phase is cut short
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      applied_reg <= SCFC_SPEED_MID;
    end else if (last_half && !phi_reg) begin
      applied_reg <= wanted;
    end
  end

  // A wait arriving with the interrupt still wins
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_reg <= 1'b0;
    end else if (wait_instruction_in) begin
      wait_reg <= 1'b1;
    end else if (int_accept_in) begin
      wait_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == `SCFC_PMR_ADDR) begin
        rdata_next = pmr_reg;
      end else if (reg_addr_in == `SCFC_STAT_ADDR) begin
        rdata_next[`SCFC_STAT_PHI_BIT]                     = phi_reg;
        rdata_next[`SCFC_STAT_MODE_MSB:`SCFC_STAT_MODE_LSB] = applied_reg;
        rdata_next[`SCFC_STAT_WAIT_BIT]                    = wait_reg;
        rdata_next[`SCFC_STAT_MAIN_BIT]                    = main_run_reg;
        rdata_next[`SCFC_STAT_SUB_BIT]                     = sub_run_reg;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

  assign main_osc_run_out  = main_run_reg;
  assign sub_osc_run_out   = sub_run_reg;
  assign sub_pins_port_out = !sub_run_reg;
  assign sys_clk_out       = phi_reg;
  assign waiting_out       = wait_reg;

  // Helper state for the checks below
  logic pmr_written_reg;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pmr_written_reg <= 1'b0;
    end else if (pmr_wr) begin
      pmr_written_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_reset_mid;
    !pmr_written_reg |-> (pmr_reg[`SCFC_SPEED_MSB:`SCFC_SPEED_LSB] == 2'b01)
                         && (applied_reg == SCFC_SPEED_MID);
  endproperty
  a_reset_mid: assert property (p_reset_mid) else $error("mode not middle before any write");

  property p_mid_ratio;
    ($changed(phi_reg) && $past(applied_reg) == SCFC_SPEED_MID)
      |-> ($past(cnt_reg) == 3'h3) && $past(main_rise);
  endproperty
  a_mid_ratio: assert property (p_mid_ratio) else $error("middle speed phase not four ticks");

  property p_high_ratio;
    (applied_reg == SCFC_SPEED_HIGH && main_rise && main_run_reg && !freeze)
      |=> $changed(phi_reg);
  endproperty
  a_high_ratio: assert property (p_high_ratio) else $error("high speed missed a toggle");

  property p_low_source;
    ($changed(phi_reg) && $past(applied_reg) == SCFC_SPEED_LOW)
      |-> $past(sub_rise) && $past(sub_run_reg);
  endproperty
  a_low_source: assert property (p_low_source) else $error("low speed toggled without sub tick");

  property p_sub_off;
    !pmr_written_reg |-> !sub_osc_run_out && sub_pins_port_out && main_osc_run_out;
  endproperty
  a_sub_off: assert property (p_sub_off) else $error("sub oscillator on after reset");

  property p_main_stop;
    (pmr_reg[`SCFC_MAIN_STOP_BIT] && applied_reg == SCFC_SPEED_LOW) ##1
      (pmr_reg[`SCFC_MAIN_STOP_BIT] && applied_reg == SCFC_SPEED_LOW) |-> !main_osc_run_out;
  endproperty
  a_main_stop: assert property (p_main_stop) else $error("main oscillator not halted");

  property p_main_restart;
    !pmr_reg[`SCFC_MAIN_STOP_BIT] |=> main_osc_run_out;
  endproperty
  a_main_restart: assert property (p_main_restart) else $error("main oscillator not restarted");

  property p_wait_hold;
    (wait_reg && phi_reg && !int_accept_in) [*2] |-> phi_reg && $stable(cnt_reg);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("clock moved during wait");

  property p_resume;
    (int_accept_in && !wait_instruction_in) |=> !wait_reg ##1 (!wait_reg || $past(wait_instruction_in));
  endproperty
  a_resume: assert property (p_resume) else $error("wait not released by interrupt");

  property p_boundary;
    $changed(applied_reg) |-> $rose(phi_reg) && (cnt_reg == 3'h0);
  endproperty
  a_boundary: assert property (p_boundary) else $error("mode changed mid period");

  property p_readback;
    (reg_rd_in && reg_addr_in == `SCFC_PMR_ADDR && !pmr_wr) |=> reg_rdata_out == $past(pmr_reg);
  endproperty
  a_readback: assert property (p_readback) else $error("mode register readback wrong");

  property p_low_ratio;
    (applied_reg == SCFC_SPEED_LOW && sub_rise && sub_run_reg && !freeze)
      |=> $changed(phi_reg);
  endproperty
  a_low_ratio: assert property (p_low_ratio) else $error("low speed missed a toggle");

  // Main ticks must not reach phi while the sub clock drives it
  property p_main_quiet;
    (applied_reg == SCFC_SPEED_LOW && !sub_rise) |=> $stable(phi_reg);
  endproperty
  a_main_quiet: assert property (p_main_quiet) else $error("low speed moved without sub tick");

  property p_stop_ignored;
    (applied_reg != SCFC_SPEED_LOW) |=> main_osc_run_out;
  endproperty
  a_stop_ignored: assert property (p_stop_ignored) else $error("main stopped outside low speed");

  property p_wait_set;
    wait_instruction_in |=> waiting_out;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("wait not taken");

  property p_wait_refused;
    (!wait_reg && !wait_instruction_in) |=> !waiting_out;
  endproperty
  a_wait_refused: assert property (p_wait_refused) else $error("wait set without request");

  property p_frozen_count;
    (wait_reg && phi_reg) |=> $stable(cnt_reg) && phi_reg;
  endproperty
  a_frozen_count: assert property (p_frozen_count) else $error("divider ran while frozen");

  // Single-edge ratios never leave a partial count behind
  property p_short_cnt;
    (applied_reg != SCFC_SPEED_MID) |-> (cnt_reg == 3'h0);
  endproperty
  a_short_cnt: assert property (p_short_cnt) else $error("stale count after ratio change");

  property p_rdata_idle;
    !reg_rd_in |=> (reg_rdata_out == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

endmodule
